// File: hdl/phy_page_regs.sv
// paged port status and identification register window behind an apb slave
`timescale 1ns/100ps
`default_nettype none
`include "phy_page_cfg.svh"

// How it works
// - window 8h-Fh chosen by register 7h
// - page zero plus port number shows port
// - a-pair line state at bits 1:0
// - b-pair line state at bits 3:2
// - bit 4 shows child one, parent zero
// - attached bit five, filtered, resets zero
// - bias bit six, filtered against scrape
// - bit seven disables port, resets zero
// - negotiated speed code at bits 2:0
// - enabled port changes set port-change flag
// - fault flag set by suspend/resume error, w1c
// - port-change flag w1c, resume also sets
// - page one shows identification bytes
// - conformance code reads one
// - maker code msb first at Ah-Ch
// - part code msb first at Dh-Fh
module phy_page_regs #(
    parameter int NUM_PORTS = 3,
    parameter logic [23:0] MAKER_CODE = 24'h5a5a01, // value is arbitrary
    parameter logic [23:0] PART_CODE = 24'h0a0b0c, // value is arbitrary
    parameter int FILTER_CYCLES = `FILTER_CYC
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // port status from the port logic
    input wire phy_page_pkg::port_status_s [NUM_PORTS-1:0] port_stat,
    input wire logic [NUM_PORTS-1:0] attach_raw,
    input wire logic [NUM_PORTS-1:0] bias_raw,
    input wire logic [NUM_PORTS-1:0] suspend_error,
    input wire logic [NUM_PORTS-1:0] resume_start,
    // port control and interrupt
    output logic [NUM_PORTS-1:0] port_disable,
    output logic irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    // filter counter width; one filter per attach and bias level
    localparam int FW = $clog2(FILTER_CYCLES + 1);
    localparam int NF = 2 * NUM_PORTS;

    // global select and event bits
    logic [7:0] select_reg;
    logic resume_int_reg;
    logic port_event_reg;

    // writable bits, one set per port
    logic [NUM_PORTS-1:0] disabled_reg;
    logic [NUM_PORTS-1:0] int_en_reg;
    logic [NUM_PORTS-1:0] fault_reg;

    // filtered levels and run counters
    logic [NF-1:0] filt_reg;
    logic [FW-1:0] filt_cnt_reg [NF];

    // last cycle's watched flags
    logic [3:0] watch_reg [NUM_PORTS];

    // sticky status and its mask
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;

    // bus answer and interrupt flops
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic irq_reg;

    // filter inputs and levels
    logic [NF-1:0] filt_raw;
    logic [NUM_PORTS-1:0] connected;
    logic [NUM_PORTS-1:0] bias;
    logic [NUM_PORTS-1:0] chg;

    // select fields and bus decodes
    logic [2:0] page_sel;
    logic [3:0] port_sel;
    logic port_ok;
    logic [5:0] idx;
    logic setup;
    logic done;
    logic wr_done;
    logic rd_done;
    logic mapped;

    // read path
    logic [7:0] win_byte;
    logic [31:0] event_word;
    logic [31:0] select_word;
    logic [31:0] rd_data;

    // next values of the flags
    logic port_event_next;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    logic [2:0] irq_stat_next;
    logic [2:0] irq_mask_next;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------

    // true when an index answers on the bus
    // any other index answers with pslverr
    function automatic logic idx_mapped(input logic [5:0] i);
        idx_mapped = (i == `IDX_EVENT) || (i == `IDX_SELECT) ||
                     (i >= `IDX_WIN0 && i <= `IDX_IRQ_MASK);
    endfunction

    // one byte of the window for the chosen page and port
    // an absent port or unused page reads zero
    function automatic logic [7:0] win_read(
        input logic [5:0] i,
        input logic [2:0] pg,
        input logic ok,
        input phy_page_pkg::port_status_s st,
        input logic con,
        input logic bi,
        input logic dis,
        input logic ien,
        input logic flt
    );
        win_read = 8'h00; // reserved reads zero
        if (pg == `PAGE_PORT && ok) begin
            if (i == `IDX_WIN0) begin
                win_read = {dis, bi, con, st.child, st.line_b, st.line_a};
            end else if (i == `IDX_WIN1) begin
                win_read = {3'h0, flt, ien, st.speed};
            end
        end else if (pg == `PAGE_IDENT) begin
            case (i)
                `IDX_WIN0: win_read = `RST_CONFORMANCE;
                `IDX_WINA: win_read = MAKER_CODE[23:16];
                `IDX_WINB: win_read = MAKER_CODE[15:8];
                `IDX_WINC: win_read = MAKER_CODE[7:0];
                `IDX_WIND: win_read = PART_CODE[23:16];
                `IDX_WINE: win_read = PART_CODE[15:8];
                `IDX_WINF: win_read = PART_CODE[7:0];
                default: win_read = 8'h00;
            endcase
        end
    endfunction

    // select fields and bus phases
    // port_ok catches port numbers past the last port,
    // since the field is wider than the port count
    assign page_sel = select_reg[2:0];
    assign port_sel = select_reg[7:4];
    assign port_ok = ({28'h0, port_sel} < NUM_PORTS);
    assign idx = paddr[7:2];
    assign setup = psel & ~penable;
    assign done = psel & penable & pready_reg;
    assign wr_done = done & pwrite & mapped;
    assign rd_done = done & ~pwrite & mapped;
    assign mapped = idx_mapped(idx);

    // window byte for the selected port
    // the narrowed index only matters when port_ok holds
    assign win_byte = win_read(idx, page_sel, port_ok,
                               port_stat[port_sel[$clog2(NUM_PORTS+1)-1:0]],
                               connected[port_sel[$clog2(NUM_PORTS+1)-1:0]],
                               bias[port_sel[$clog2(NUM_PORTS+1)-1:0]],
                               disabled_reg[port_sel[$clog2(NUM_PORTS+1)-1:0]],
                               int_en_reg[port_sel[$clog2(NUM_PORTS+1)-1:0]],
                               fault_reg[port_sel[$clog2(NUM_PORTS+1)-1:0]]);

    // words outside the window
    assign event_word = {24'h0, 2'h0, port_event_reg, 4'h0, resume_int_reg};
    assign select_word = {24'h0, select_reg[7:4], 1'b0, select_reg[2:0]};

    // read mux; unmapped indices read zero
    assign rd_data = (idx == `IDX_EVENT) ? event_word :
                     (idx == `IDX_SELECT) ? select_word :
                     (idx == `IDX_IRQ_STAT) ? {29'h0, irq_stat_reg} :
                     (idx == `IDX_IRQ_MASK) ? {29'h0, irq_mask_reg} :
                     (idx >= `IDX_WIN0 && idx <= `IDX_WINF) ? {24'h0, win_byte} : 32'h0;

    // ------------------------------------------------------------
    // contact scrape filters
    // ------------------------------------------------------------
    // attach filters low, bias filters high
    assign filt_raw = {bias_raw, attach_raw};
    assign connected = filt_reg[NUM_PORTS-1:0];
    assign bias = filt_reg[NF-1:NUM_PORTS];

    // a level must hold for the whole filter time before it shows,
    // so scrape bursts shorter than that never reach the flags;
    // the price is that a real plug change shows that much later
    // and a level that keeps flickering keeps its old value
    genvar g;
    generate
        for (g = 0; g < NF; g = g + 1) begin : g_filt
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    filt_reg[g] <= 1'b0;
                    filt_cnt_reg[g] <= '0;
                end else if (ce) begin
                    // agreement restarts the run
                    if (filt_raw[g] == filt_reg[g]) begin
                        filt_cnt_reg[g] <= '0;
                    end else if (filt_cnt_reg[g] == FW'(FILTER_CYCLES - 1)) begin
                        // run complete: take the new level
                        filt_reg[g] <= filt_raw[g];
                        filt_cnt_reg[g] <= '0;
                    end else begin
                        filt_cnt_reg[g] <= filt_cnt_reg[g] + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // per-port control and fault
    // ------------------------------------------------------------
    generate
        for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_port
            // write strobes of this port's two bytes
            logic sel_me;
            logic w0;
            logic w1;

            // only a port-page write aimed at this port lands
            assign sel_me = port_ok && (port_sel == 4'(g)) && (page_sel == `PAGE_PORT);
            assign w0 = wr_done && sel_me && (idx == `IDX_WIN0);
            assign w1 = wr_done && sel_me && (idx == `IDX_WIN1);
            // watched flags: connected, bias, disabled, fault
            // any difference from last cycle is a change
            assign chg[g] = watch_reg[g] != {connected[g], bias[g], disabled_reg[g], fault_reg[g]};

            // only the writable bits of the chosen port are stored
            // read-only fields in the same byte are dropped
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    disabled_reg[g] <= 1'b0;
                    int_en_reg[g] <= 1'b0;
                    fault_reg[g] <= 1'b0;
                    watch_reg[g] <= 4'h0;
                end else if (ce) begin
                    if (w0) begin
                        disabled_reg[g] <= pwdata[`BIT_DISABLED];
                    end
                    if (w1) begin
                        int_en_reg[g] <= pwdata[`BIT_INT_EN];
                    end
                    // error set wins over a write-one clear
                    if (suspend_error[g]) begin
                        fault_reg[g] <= 1'b1;
                    end else if (w1 && pwdata[`BIT_FAULT]) begin
                        fault_reg[g] <= 1'b0;
                    end
                    watch_reg[g] <= {connected[g], bias[g], disabled_reg[g], fault_reg[g]};
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // global flags and select register
    // ------------------------------------------------------------

    // port-change: set wins over the write-one clear
    // so a change during the clear is never lost
    assign port_event_next = (|(chg & int_en_reg)) ||
                             (resume_int_reg && |resume_start) ||
                             (port_event_reg &&
                              !(wr_done && idx == `IDX_EVENT && pwdata[`BIT_PORT_EVENT]));

    // select, resume enable and port-change flag
    // bit 3 of the select word is not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_reg <= `RST_SELECT;
            resume_int_reg <= 1'b0;
            port_event_reg <= 1'b0;
        end else if (ce) begin
            if (wr_done && idx == `IDX_SELECT) begin
                select_reg <= {pwdata[7:4], 1'b0, pwdata[2:0]};
            end
            if (wr_done && idx == `IDX_EVENT) begin
                resume_int_reg <= pwdata[`BIT_RESUME_INT];
            end
            // next value already holds both set and clear
            port_event_reg <= port_event_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------

    // sticky events; a read clears only the bits it returned,
    // so an event arriving during the read is kept for the next one
    // fault and resume merge all ports into one bit each
    assign irq_set[`IRQ_PORT_EVENT] = port_event_next & ~port_event_reg;
    assign irq_set[`IRQ_FAULT] = |suspend_error;
    assign irq_set[`IRQ_RESUME] = |resume_start;
    assign irq_clr = (rd_done && idx == `IDX_IRQ_STAT) ? prdata_reg[2:0] : 3'h0;
    assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

    // irq follows a new mask at once; the old mask
    // would leave the level a cycle late after each write
    assign irq_mask_next = (wr_done && idx == `IDX_IRQ_MASK) ? pwdata[2:0] : irq_mask_reg;

    // status, mask and the level output
    // irq is registered so the pin never glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= `RST_MASK;
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= |(irq_stat_next & irq_mask_next);
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------

    // no wait state: data is caught in setup, pready rises in the first access cycle
    // a flag that moves in the access cycle shows
    // on the next read instead of this one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            pready_reg <= setup;
            if (setup) begin
                // writes answer zero data
                prdata_reg <= pwrite ? 32'h0 : rd_data;
                pslverr_reg <= ~mapped;
            end
        end
    end

    // outputs straight from flip-flops
    // disable pins follow the stored bits directly
    // so a write takes effect the next cycle
    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign port_disable = disabled_reg;

endmodule // phy_page_regs

`default_nettype wire

// File: hdl/phy_page_cfg.svh
// offsets, field positions, reset values and timing counts of the paged registers
`ifndef PHY_PAGE_CFG_SVH
`define PHY_PAGE_CFG_SVH

// register indices; the byte address is four times the index
`define IDX_EVENT 6'h05
`define IDX_SELECT 6'h07
`define IDX_WIN0 6'h08
`define IDX_WIN1 6'h09
`define IDX_WINA 6'h0a
`define IDX_WINB 6'h0b
`define IDX_WINC 6'h0c
`define IDX_WIND 6'h0d
`define IDX_WINE 6'h0e
`define IDX_WINF 6'h0f
`define IDX_IRQ_STAT 6'h10
`define IDX_IRQ_MASK 6'h11

// page numbers
`define PAGE_PORT 3'h0
`define PAGE_IDENT 3'h1

// field positions
`define BIT_RESUME_INT 0
`define BIT_PORT_EVENT 5
`define BIT_DISABLED 7
`define BIT_INT_EN 3
`define BIT_FAULT 4

// irq status bit positions
`define IRQ_PORT_EVENT 0
`define IRQ_FAULT 1
`define IRQ_RESUME 2

// reset values
`define RST_CONFORMANCE 8'h01
`define RST_SELECT 8'h00
`define RST_MASK 3'h0

// contact scrape filter: least stable time, in ns, at the 40 MHz pclk
`define FILTER_NS 2000
`define PCLK_MHZ 40
`define FILTER_CYC ((`FILTER_NS * `PCLK_MHZ + 999) / 1000)

`endif

// File: hdl/phy_page_pkg.sv
// types shared by the paged port and identification registers
package phy_page_pkg;

    // line state code of one cable pair
    typedef enum logic [1:0] {
        LINE_INVALID = 2'h0,
        LINE_ONE = 2'h1,
        LINE_ZERO = 2'h2,
        LINE_HIGHZ = 2'h3
    } line_state_e;

    // negotiated speed code
    typedef enum logic [2:0] {
        SPEED_BASE = 3'h0,
        SPEED_DOUBLE = 3'h1,
        SPEED_QUAD = 3'h2
    } speed_e;

    // live status of one port, as the port logic reports it
    typedef struct packed {
        line_state_e line_a;
        line_state_e line_b;
        logic child;
        speed_e speed;
    } port_status_s;

endpackage

// File: tb/phy_page_regs_props.sv
// assertion checker for the paged port and identification register window
`timescale 1ns/100ps
`default_nettype none
module phy_page_regs_props #(
    parameter int NUM_PORTS = 3,
    parameter int FILTER_CYCLES = 4
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // port side
    input wire phy_page_pkg::port_status_s [NUM_PORTS-1:0] port_stat,
    input wire logic [NUM_PORTS-1:0] attach_raw,
    input wire logic [NUM_PORTS-1:0] bias_raw,
    input wire logic [NUM_PORTS-1:0] suspend_error,
    input wire logic [NUM_PORTS-1:0] resume_start,
    input wire logic [NUM_PORTS-1:0] port_disable,
    input wire logic irq
);
    // mirror of the page and port choice, so window reads can be judged
    logic [2:0] page_reg;
    logic [3:0] port_reg;
    wire logic wr_done = psel && penable && pwrite && pready;
    wire logic rd_done = psel && penable && !pwrite && pready && !pslverr;
    wire logic port_page = (page_reg == 3'h0) && (port_reg < NUM_PORTS);
    wire logic [5:0] idx = paddr[7:2];
    wire phy_page_pkg::port_status_s cur_st = port_stat[port_reg];

    // select mirror updates only at the completing edge of a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_reg <= 3'h0;
            port_reg <= 4'h0;
        end else if (wr_done && idx == 6'h07) begin
            page_reg <= pwdata[2:0];
            port_reg <= pwdata[7:4];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    a_ready_timely: assert property (psel && !penable && ce |=> pready)
        else $error("no ready in first access cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_line_role_read: assert property (rd_done && idx == 6'h08 && port_page |->
        prdata[4:0] == {$past(cur_st.child), $past(cur_st.line_b), $past(cur_st.line_a)} && prdata[31:8] == 24'h0)
        else $error("line state or role field wrong");
    a_speed_read: assert property (rd_done && idx == 6'h09 && port_page |->
        prdata[2:0] == $past(cur_st.speed) && prdata[31:5] == 27'h0)
        else $error("speed field wrong");
    a_conform_read: assert property (rd_done && idx == 6'h08 && page_reg == 3'h1 |-> prdata == 32'h1)
        else $error("conformance code wrong");
    a_ident_gap: assert property (rd_done && idx == 6'h09 && page_reg == 3'h1 |-> prdata == 32'h0)
        else $error("reserved ident place not zero");
    a_unmapped_err: assert property (pready && idx > 6'h11 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_disable_cause: assert property ($changed(port_disable) |-> $past(wr_done) && $past(idx) == 6'h08)
        else $error("disable pins moved without a write");

    // main scenarios reached
    c_disable_set: cover property (wr_done && idx == 6'h08 && pwdata[7]);
    c_err_seen: cover property (pready && pslverr);
    c_irq_rise: cover property ($rose(irq));
endmodule // phy_page_regs_props

bind phy_page_regs phy_page_regs_props #(.NUM_PORTS(NUM_PORTS), .FILTER_CYCLES(FILTER_CYCLES)) phy_page_regs_props_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .port_stat(port_stat), .attach_raw(attach_raw), .bias_raw(bias_raw), .suspend_error(suspend_error),
    .resume_start(resume_start), .port_disable(port_disable), .irq(irq));
`default_nettype wire

// File: tb/link_model.sv
// link-side apb master model issuing register reads and writes
`timescale 1ns/100ps
`default_nettype none
module link_model (
    // clock
    input wire logic pclk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one transfer; entered just after a rising edge, leaves one idle edge
    // behind so no signal is driven twice in a time step
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd; // released data must not keep showing the last value
        @(posedge pclk);
    endtask
endmodule // link_model
`default_nettype wire

// File: tb/tb_top.sv
// self-checking testbench for the paged port and identification registers
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [23:0] MAKER = 24'h3c2d1e; // value is arbitrary
    localparam logic [23:0] PART = 24'h0f1e2d; // value is arbitrary
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    phy_page_pkg::port_status_s [2:0] port_stat;
    logic [2:0] attach_raw, bias_raw, suspend_error, resume_start, port_disable;
    int mismatches, checks;

    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    phy_page_regs #(.NUM_PORTS(3), .MAKER_CODE(MAKER), .PART_CODE(PART), .FILTER_CYCLES(4)) phy_page_regs_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .port_stat(port_stat), .attach_raw(attach_raw), .bias_raw(bias_raw), .suspend_error(suspend_error),
        .resume_start(resume_start), .port_disable(port_disable), .irq(irq));
    link_model link_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        link_i.xfer(1'b1, a, d, rdat, err);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        link_i.xfer(1'b0, a, 32'h0, rdat, err);
        chk(rdat, exp, what);
    endtask
    task automatic sel(input logic [2:0] pg, input logic [3:0] pt);
        wr(8'h1c, {24'h0, pt, 1'b0, pg});
    endtask
    // port p shows line_a = p, line_b = 3 - p, child = p[0], speed = p
    function automatic logic [31:0] win0(int p, logic c, logic b, logic d);
        return {24'h0, d, b, c, p[0], 2'(3 - p), p[1:0]};
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        for (int p = 0; p < 3; p++) port_stat[p] = {2'(p), 2'(3 - p), 1'(p), 3'(p)};
        {attach_raw, bias_raw, suspend_error, resume_start} = 12'h000;
        mismatches = 0;
        checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(8'h1c, 32'h0, "select reset");
        for (int p = 0; p < 3; p++) begin
            sel(3'h0, 4'(p));
            rd_chk(8'h20, win0(p, 1'b0, 1'b0, 1'b0), "status word");
            rd_chk(8'h24, 32'(p), "speed word");
        end
        $display("test reset_and_status done");
        sel(3'h0, 4'h0);
        attach_raw <= 3'h1;
        repeat (3) @(posedge pclk);
        attach_raw <= 3'h0;
        rd_chk(8'h20, win0(0, 1'b0, 1'b0, 1'b0), "scrape ignored");
        attach_raw <= 3'h1;
        bias_raw <= 3'h1;
        repeat (8) @(posedge pclk);
        rd_chk(8'h20, win0(0, 1'b1, 1'b1, 1'b0), "attach and bias shown");
        $display("test filter done");
        sel(3'h0, 4'h1);
        wr(8'h20, 32'h7f);
        rd_chk(8'h20, win0(1, 1'b0, 1'b0, 1'b0), "read-only write");
        wr(8'h20, 32'h80);
        chk(32'(port_disable), 32'h2, "disable pins");
        rd_chk(8'h20, win0(1, 1'b0, 1'b0, 1'b1), "disable bit");
        sel(3'h0, 4'h2);
        rd_chk(8'h20, win0(2, 1'b0, 1'b0, 1'b0), "other port disable");
        ce <= 1'b0;
        suspend_error <= 3'h4;
        @(posedge pclk);
        ce <= 1'b1;
        suspend_error <= 3'h0;
        rd_chk(8'h24, 32'h02, "frozen fault");
        sel(3'h0, 4'h3);
        rd_chk(8'h20, 32'h0, "absent port");
        sel(3'h2, 4'h0);
        rd_chk(8'h20, 32'h0, "empty page");
        $display("test disable done");
        sel(3'h0, 4'h1);
        wr(8'h24, 32'h08);
        rd_chk(8'h24, 32'h09, "int enable");
        wr(8'h20, 32'h00);
        rd_chk(8'h14, 32'h20, "event from disable");
        wr(8'h14, 32'h20);
        rd_chk(8'h14, 32'h0, "event cleared");
        wr(8'h14, 32'h01);
        resume_start <= 3'h4;
        @(posedge pclk);
        resume_start <= 3'h0;
        rd_chk(8'h14, 32'h21, "event from resume");
        wr(8'h14, 32'h21);
        rd_chk(8'h14, 32'h01, "event cleared again");
        suspend_error <= 3'h2;
        @(posedge pclk);
        suspend_error <= 3'h0;
        rd_chk(8'h24, 32'h19, "fault set");
        rd_chk(8'h14, 32'h21, "event from fault");
        wr(8'h24, 32'h18);
        rd_chk(8'h24, 32'h09, "fault cleared");
        $display("test events done");
        link_i.xfer(1'b0, 8'h40, 32'h0, rdat, err);
        suspend_error <= 3'h1;
        @(posedge pclk);
        suspend_error <= 3'h0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(32'(irq), 32'h0, "masked irq");
        @(posedge pclk);
        wr(8'h44, 32'h02);
        rd_chk(8'h44, 32'h02, "mask readback");
        chk(32'(irq), 32'h1, "unmasked irq");
        rd_chk(8'h40, 32'h02, "irq status");
        @(negedge pclk);
        chk(32'(irq), 32'h0, "irq after read");
        @(posedge pclk);
        $display("test irq done");
        sel(3'h1, 4'h0);
        wr(8'h20, 32'hff);
        rd_chk(8'h20, 32'h1, "conformance");
        rd_chk(8'h24, 32'h0, "ident reserved");
        for (int i = 0; i < 3; i++) begin
            rd_chk(8'h28 + 8'(4 * i), {24'h0, MAKER[23 - 8 * i -: 8]}, "maker byte");
            rd_chk(8'h34 + 8'(4 * i), {24'h0, PART[23 - 8 * i -: 8]}, "part byte");
        end
        rd_chk(8'h60, 32'h0, "unmapped data");
        chk(32'(err), 32'h1, "unmapped error");
        $display("test ident done");
        final_report();
    end

    // watchdog sized well above the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end
endmodule // tb_top
`default_nettype wire
